/* rtl/cec_event_counter.v */
// Operation
// - Count one per falling event pin edge
// - Two 8-bit stages chained as 16-bit
// - Running match raises irq, clears counter
// - After clear, keep counting from zero
// - Match registers unbuffered, take effect immediately
`timescale 1ns/10ps
`default_nettype none
`include "cec_map.vh"

// One flip-flop with a chosen reset level
module cec_flop #(
  parameter [0:0] RESET_VALUE = 1'b0
) (
  input  wire i_core_clk,
  input  wire i_reset,
  input  wire i_d,
  output wire o_q
);

  reg value_q;

  assign o_q = value_q;

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= i_d;
    end
  end

endmodule

module cec_stage #(
  parameter WIDTH = `CEC_STAGE_W
) (
  input  wire             i_core_clk,
  input  wire             i_reset,
  input  wire             i_clear,
  input  wire             i_step,
  output wire [WIDTH-1:0] o_value,
  output wire             o_wrap
);

  reg  [WIDTH-1:0] value_q;
  reg  [WIDTH-1:0] value_d;

  assign o_value = value_q;
  // All ones: the next step rolls this stage over
  assign o_wrap  = &value_q;

  // Clear wins over a step arriving in the same cycle
  always @* begin
    value_d = value_q;
    if (i_clear) begin
      value_d = {WIDTH{1'b0}};
    end else if (i_step) begin
      value_d = value_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      value_q <= {WIDTH{1'b0}};
    end else begin
      value_q <= value_d;
    end
  end

endmodule

module cec_event_counter (
  input  wire                     i_core_clk,
  input  wire                     i_reset,
  input  wire                     i_event_count_pin,
  input  wire [`CEC_STAGE_W-1:0]  i_match_value_low,
  input  wire [`CEC_STAGE_W-1:0]  i_match_value_high,
  input  wire                     i_upper_stage_run,
  output reg                      o_cascade_match_irq,
  output wire [`CEC_COUNT_W-1:0]  o_count
);

  // Latency: a pin fall shows in o_count three clocks later
  // (two synchroniser flops, then the counter; the edge compare is combinational).
  // The count is compared with the match value on every clock
  // while running, so a match clears it one cycle after reaching it.
  // A match value of zero with the run bit set fires every clock,
  // since the counter sits at zero and keeps matching.
  // Dropping the run bit clears both stages.

  // Pin synchroniser and falling edge detector
  wire                    sync1_q;
  wire                    sync2_q;
  wire                    prev_q;

  // Control decode
  reg                     fall_edge;
  reg                     match_hit;
  reg                     clear_req;
  reg                     step_req;
  reg                     irq_d;

  // Stage outputs and the assembled values
  wire [`CEC_STAGE_W-1:0] low_value;
  wire [`CEC_STAGE_W-1:0] high_value;
  wire                    low_wrap;
  wire                    high_step;
  wire [`CEC_COUNT_W-1:0] count_value;
  wire [`CEC_COUNT_W-1:0] match_value;

  // Pin is asynchronous; idle high at reset, so a pin held low out of reset counts as one edge
  cec_flop #(
    .RESET_VALUE (`CEC_PIN_IDLE)
  ) i_sync1 (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_d         (i_event_count_pin),
    .o_q         (sync1_q)
  );

  // Second flop, the only reader of the first
  cec_flop #(
    .RESET_VALUE (`CEC_PIN_IDLE)
  ) i_sync2 (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_d         (sync1_q),
    .o_q         (sync2_q)
  );

  // Previous synchronised level for the edge detector
  cec_flop #(
    .RESET_VALUE (`CEC_PIN_IDLE)
  ) i_prev (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_d         (sync2_q),
    .o_q         (prev_q)
  );

  // Match value is used live, with no shadow copy
  assign match_value = {i_match_value_high, i_match_value_low};

  always @* begin
    fall_edge = prev_q & ~sync2_q;
  end

  always @* begin
    match_hit = (count_value == match_value);
  end

  // Run low or a match clears both stages
  always @* begin
    clear_req = 1'b0;
    if (!i_upper_stage_run) begin
      clear_req = 1'b1;
    end else if (match_hit) begin
      clear_req = 1'b1;
    end
  end

  // An edge that lands in the clearing cycle is dropped
  always @* begin
    step_req = 1'b0;
    if (i_upper_stage_run && !match_hit && fall_edge) begin
      step_req = 1'b1;
    end
  end

  always @* begin
    irq_d = 1'b0;
    if (i_upper_stage_run && match_hit) begin
      irq_d = 1'b1;
    end
  end

  // Upper stage steps only when the lower one rolls over
  assign high_step = step_req & low_wrap;

  // Lower stage counts every accepted edge
  cec_stage #(
    .WIDTH      (`CEC_STAGE_W)
  ) i_low_stage (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clear    (clear_req),
    .i_step     (step_req),
    .o_value    (low_value),
    .o_wrap     (low_wrap)
  );

  cec_stage #(
    .WIDTH      (`CEC_STAGE_W)
  ) i_high_stage (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clear    (clear_req),
    .i_step     (high_step),
    .o_value    (high_value),
    .o_wrap     ()
  );

  // Count is {upper, lower}
  assign count_value = {high_value, low_value};
  assign o_count     = count_value;

  // The match pulse is registered and lasts one cycle unless the match value is zero
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cascade_match_irq <= 1'b0;
    end else begin
      o_cascade_match_irq <= irq_d;
    end
  end

endmodule
`default_nettype wire

/* inc/cec_map.vh */
`ifndef CEC_MAP_VH
`define CEC_MAP_VH

// Counter and match widths
`define CEC_STAGE_W      8
`define CEC_COUNT_W      16
// Reset values
`define CEC_COUNT_RST    16'h0000
`define CEC_STAGE_RST    8'h00
// Synchroniser depth before edge detection
`define CEC_SYNC_STAGES  2
// Idle level of the event pin, loaded into the synchroniser at reset
`define CEC_PIN_IDLE     1'b1

`endif

/* verif/cec_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module cec_chk(input wire logic i_core_clk,i_reset,i_upper_stage_run,o_cascade_match_irq,
  input wire logic [7:0] i_match_value_low,i_match_value_high,input wire logic [15:0] o_count);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire logic [15:0] m = {i_match_value_high,i_match_value_low};
  property p_match; i_upper_stage_run && o_count==m |=> o_cascade_match_irq && o_count==16'h0000; endproperty
  a_match: assert property(p_match) else $error("no clear on match");
  property p_step; i_upper_stage_run && o_count!=m |=> o_count==$past(o_count) || o_count==$past(o_count)+16'h0001;
  endproperty
  a_step: assert property(p_step) else $error("count jumped");
  property p_irq; o_cascade_match_irq |-> $past(o_count)==$past(m) && o_count==16'h0000; endproperty
  a_irq: assert property(p_irq) else $error("irq without match");
  property p_stop; !i_upper_stage_run |=> o_count==16'h0000 && !o_cascade_match_irq; endproperty
  a_stop: assert property(p_stop) else $error("count not held at zero");
  property p_pulse; o_cascade_match_irq && m!=16'h0000 |=> !o_cascade_match_irq; endproperty
  a_pulse: assert property(p_pulse) else $error("irq longer than one cycle");
  property p_hold; i_upper_stage_run && o_count!=m && o_count[7:0]!=8'hff |=> o_count[15:8]==$past(o_count[15:8]);
  endproperty
  a_hold: assert property(p_hold) else $error("upper stage moved without carry");
  cover property(o_cascade_match_irq);
  cover property(o_count==16'h00ff ##1 o_count==16'h0100);
  cover property(o_count==16'h0001);
endmodule
`default_nettype wire

/* verif/cec_pulse_src.sv */
`timescale 1ns/10ps
`default_nettype none
module cec_src(output var logic o_pin);
  initial o_pin = 1'b1;
  // Each level held 8 clocks, well inside the minimum width and rate
  task automatic fall(input int n); repeat (n) begin #64 o_pin = 1'b0; #64 o_pin = 1'b1; end endtask
endmodule
`default_nettype wire

/* verif/test_cec_event_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module test_cec_event_counter;
  logic clk = 0, rst = 1, run = 0, pin;
  logic [15:0] m = 16'h0102; // Low byte then high, never changed while running
  // This block has no toggle init port; besides clk and rst the bench drives only pin, run and m
  wire irq;
  wire [15:0] cnt;
  int err_count, n_tests, ni;
  always #4 clk = ~clk;
  cec_src i_src(.o_pin(pin));
  cec_event_counter i_dut(.i_core_clk(clk), .i_reset(rst), .i_event_count_pin(pin), .i_match_value_low(m[7:0]),
    .i_match_value_high(m[15:8]), .i_upper_stage_run(run), .o_cascade_match_irq(irq), .o_count(cnt));
  always @(posedge clk) if (irq === 1'b1) ni++;
  task chk(input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin err_count++; $display("wrong value %0t count %h", $time, s); end
  endtask
  task close_out;
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 0; run = 1;
    i_src.fall(255); chk(cnt, 16'h00ff);
    i_src.fall(1); chk(cnt, 16'h0100);
    i_src.fall(2); chk(cnt, 16'h0000);
    chk(ni[15:0], 16'h0001);
    i_src.fall(1); chk(cnt, 16'h0001);
    run = 0;
    repeat (2) @(posedge clk);
    #1 chk(cnt, 16'h0000);
    i_src.fall(1); chk(cnt, 16'h0000);
    chk(ni[15:0], 16'h0001);
    close_out;
  end
endmodule
bind cec_event_counter cec_chk i_chk(.i_core_clk, .i_reset, .i_upper_stage_run, .o_cascade_match_irq,
  .i_match_value_low, .i_match_value_high, .o_count);
`default_nettype wire
